// [src/crf_core.sv]
// working register file, pointer unit and configuration change guard
`timescale 1ns/1ps
`default_nettype none
`include "crf_defs.svh"
module crf_core
(
   // clock and reset
   input  wire logic                mclk_in,
   input  wire logic                rst_in,
   // register file read ports
   input  wire logic [4:0]          rd_a_addr_in,
   input  wire logic [4:0]          rd_b_addr_in,
   input  wire logic                imm_op_in,
   output logic [7:0]               rd_a_data_out,
   output logic [7:0]               rd_b_data_out,
   // register file write port
   input  wire logic                wr_en_in,
   input  wire logic [4:0]          wr_addr_in,
   input  wire logic [7:0]          wr_data_in,
   // pointer unit
   input  wire crf_pkg::crf_psel_e  ptr_sel_in,
   input  wire crf_pkg::crf_pmode_e ptr_mode_in,
   input  wire logic [5:0]          ptr_disp_in,
   input  wire logic                ptr_upd_in,
   output logic [15:0]              ptr_addr_out,
   output logic [23:0]              prog_addr_out,
   // i/o register access
   input  wire logic                io_wr_in,
   input  wire logic                io_rd_in,
   input  wire logic [5:0]          io_addr_in,
   input  wire logic [7:0]          io_wdata_in,
   output logic [7:0]               io_rdata_out,
   output logic [15:0]              stack_pointer_out,
   // result flags from the alu
   input  wire logic                flags_wr_in,
   input  wire logic [7:0]          flags_in,
   output logic [7:0]               result_flags_out,
   // protection events
   input  wire logic                insn_done_in,
   input  wire logic                mem_wr_in,
   input  wire logic                nv_access_in,
   input  wire logic                sleep_in,
   output logic                     io_unlock_out,
   output logic                     spm_unlock_out,
   // interrupt gate
   input  wire logic                irq_req_in,
   output logic                     irq_take_out,
   // debug
   input  wire logic                halted_in,
   input  wire logic                dbg_wr_in,
   input  wire logic [4:0]          dbg_addr_in,
   input  wire logic [7:0]          dbg_data_in,
   input  wire logic                bp_pc_en_in,
   input  wire logic [16:0]         bp_pc_in,
   input  wire logic [16:0]         program_counter_in,
   input  wire logic                cof_brk_en_in,
   input  wire logic                cof_in,
   input  wire logic                irq_brk_en_in,
   input  wire logic                irq_entry_in,
   input  wire logic                brk_insn_in,
   output logic                     break_out
);
   import crf_pkg::*;

   crf_state_s  state_reg;   // registered state
   crf_state_s  state_next;  // next state
   logic [4:0]  a_eff;       // port a index after immediate mapping
   logic [4:0]  w_eff;       // write index after immediate mapping
   logic [4:0]  lo_idx;      // low byte index of selected pointer
   logic [15:0] ptr_base;    // selected pointer value
   logic [15:0] ptr_eff;     // address presented to memory
   logic        key_wr;      // cpu writes the key register
   logic        sig_io;      // io signature written
   logic        sig_spm;     // spm signature written
   logic        io_cancel;   // event closing io window
   logic        spm_cancel;  // event closing spm window

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   // immediate ops only see the upper half: force the top index bit
   always_comb
   begin
      a_eff = imm_op_in ? {1'b1, rd_a_addr_in[3:0]} : rd_a_addr_in;
      w_eff = imm_op_in ? {1'b1, wr_addr_in[3:0]} : wr_addr_in;
   end

   // pointer selection and addressing form
   always_comb
   begin
      case (ptr_sel_in)
         CRF_PTR_X: lo_idx = `CRF_PTR_X_LO;
         CRF_PTR_Y: lo_idx = `CRF_PTR_Y_LO;
         CRF_PTR_Z: lo_idx = `CRF_PTR_Z_LO;
         default:   lo_idx = `CRF_PTR_Z_LO;
      endcase
      // low register carries the low byte
      ptr_base = {state_reg.gpr[lo_idx + 5'h01], state_reg.gpr[lo_idx]};
      case (ptr_mode_in)
         CRF_PM_DISP: ptr_eff = ptr_base + {10'h000, ptr_disp_in};
         CRF_PM_INC:  ptr_eff = ptr_base;
         CRF_PM_DEC:  ptr_eff = ptr_base - 16'h0001;
         default:     ptr_eff = ptr_base;
      endcase
   end

   // protection signature decode
   always_comb
   begin
      key_wr     = io_wr_in && (io_addr_in == `CRF_OFS_KEY);
      sig_io     = key_wr && (io_wdata_in == `CRF_SIG_IO);
      sig_spm    = key_wr && (io_wdata_in == `CRF_SIG_SPM);
      // any io or data write, nv access or sleep ends the io window
      io_cancel  = io_wr_in || mem_wr_in || nv_access_in || sleep_in;
      // only nv traffic or sleep ends the spm window
      spm_cancel = nv_access_in || sleep_in;
   end

   // next state
   always_comb
   begin
      state_next = state_reg;
      state_next.brk = 1'b0;
      // alu and load writes; single-cycle, visible on the next edge
      if (wr_en_in)
      begin
         state_next.gpr[w_eff] = wr_data_in;
      end
      // pointer write back; wins over a plain write to the pair
      if (ptr_upd_in && (ptr_mode_in == CRF_PM_INC))
      begin
         {state_next.gpr[lo_idx + 5'h01], state_next.gpr[lo_idx]} = ptr_base + 16'h0001;
      end
      else if (ptr_upd_in && (ptr_mode_in == CRF_PM_DEC))
      begin
         {state_next.gpr[lo_idx + 5'h01], state_next.gpr[lo_idx]} = ptr_eff;
      end
      // debugger edits only while execution is stopped
      if (dbg_wr_in && halted_in)
      begin
         state_next.gpr[dbg_addr_in] = dbg_data_in;
      end
      // alu flag update; an io write to the flags offset in the same cycle takes over
      if (flags_wr_in)
      begin
         state_next.flags = flags_in;
      end
      // i/o register writes
      if (io_wr_in)
      begin
         case (io_addr_in)
            `CRF_OFS_EXT:   state_next.ext = io_wdata_in & `CRF_EXT_MASK;
            `CRF_OFS_SPL:   state_next.sp[7:0] = io_wdata_in;
            `CRF_OFS_SPH:   state_next.sp[15:8] = io_wdata_in;
            `CRF_OFS_FLAGS: state_next.flags = io_wdata_in;
            default:        ;
         endcase
      end
      // window bookkeeping: count retired instructions
      case (state_reg.win)
         CRF_WIN_IO:
         begin
            if (io_cancel)
            begin
               state_next.win = CRF_WIN_IDLE;
            end
            else if (insn_done_in)
            begin
               state_next.cnt = state_reg.cnt - 3'h1;
               if (state_reg.cnt == 3'h1)
               begin
                  state_next.win = CRF_WIN_IDLE;
               end
            end
         end
         CRF_WIN_SPM:
         begin
            if (spm_cancel)
            begin
               state_next.win = CRF_WIN_IDLE;
            end
            else if (insn_done_in)
            begin
               state_next.cnt = state_reg.cnt - 3'h1;
               if (state_reg.cnt == 3'h1)
               begin
                  state_next.win = CRF_WIN_IDLE;
               end
            end
         end
         default: state_next.win = CRF_WIN_IDLE;
      endcase
      // a fresh signature reloads the count and sets the mode;
      // the signature write itself is not a cancelling event
      if (sig_io)
      begin
         state_next.win = CRF_WIN_IO;
         state_next.cnt = `CRF_WIN_INSNS;
      end
      else if (sig_spm)
      begin
         state_next.win = CRF_WIN_SPM;
         state_next.cnt = `CRF_WIN_INSNS;
      end
      // registered read data, valid the cycle after io_rd_in
      state_next.rdata = 8'h00;
      if (io_rd_in)
      begin
         case (io_addr_in)
            `CRF_OFS_KEY:
            begin
               state_next.rdata[`CRF_KEY_IO_BIT]  = (state_reg.win == CRF_WIN_IO);
               state_next.rdata[`CRF_KEY_SPM_BIT] = (state_reg.win == CRF_WIN_SPM);
            end
            `CRF_OFS_EXT:   state_next.rdata = state_reg.ext;
            `CRF_OFS_SPL:   state_next.rdata = state_reg.sp[7:0];
            `CRF_OFS_SPH:   state_next.rdata = state_reg.sp[15:8];
            `CRF_OFS_FLAGS: state_next.rdata = state_reg.flags;
            default:        state_next.rdata = 8'h00;  // reserved reads zero
         endcase
      end
      // breakpoint sources; none fire while already stopped
      if (!halted_in)
      begin
         state_next.brk = (bp_pc_en_in && (program_counter_in == bp_pc_in))
                        || (cof_brk_en_in && cof_in)
                        || (irq_brk_en_in && irq_entry_in)
                        || brk_insn_in;
      end
   end

   // state register; working registers clear at reset for determinism
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_reg       <= '0;
         state_reg.ext   <= `CRF_EXT_RESET;
         state_reg.sp    <= `CRF_SP_RESET;
         state_reg.flags <= `CRF_FLAGS_RESET;
         state_reg.win   <= CRF_WIN_IDLE;
         state_reg.rdata <= `CRF_KEY_RESET;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // outputs
   always_comb
   begin
      rd_a_data_out     = state_reg.gpr[a_eff];
      rd_b_data_out     = state_reg.gpr[rd_b_addr_in];
      ptr_addr_out      = ptr_eff;
      // program memory always goes through the third pointer
      prog_addr_out     = {state_reg.ext, state_reg.gpr[`CRF_PTR_Z_LO + 5'h01],
                           state_reg.gpr[`CRF_PTR_Z_LO]};
      io_rdata_out      = state_reg.rdata;
      stack_pointer_out = state_reg.sp;
      result_flags_out  = state_reg.flags;
      io_unlock_out     = (state_reg.win == CRF_WIN_IO);
      spm_unlock_out    = (state_reg.win == CRF_WIN_SPM);
      // requests stay pending upstream; only the take is held off
      irq_take_out      = irq_req_in && (state_reg.win == CRF_WIN_IDLE);
      break_out         = state_reg.brk;
   end

   sequence s_io_sig;
      sig_io && !halted_in;
   endsequence
   sequence s_quiet_insn;
      insn_done_in && !io_cancel && !key_wr;
   endsequence

   a_imm_upper_half: assert property (wr_en_in && imm_op_in && !ptr_upd_in && !dbg_wr_in
      |=> state_reg.gpr[{1'b1, $past(wr_addr_in[3:0])}] == $past(wr_data_in))
      else $error("immediate write missed upper half");
   a_rf_one_cycle: assert property (wr_en_in && !imm_op_in && !ptr_upd_in && !dbg_wr_in
      |=> state_reg.gpr[$past(wr_addr_in)] == $past(wr_data_in))
      else $error("register write not done in one cycle");
   a_ptr_byte_order: assert property (ptr_sel_in == CRF_PTR_Y && ptr_mode_in == CRF_PM_INC
      |-> ptr_addr_out == {state_reg.gpr[29], state_reg.gpr[28]})
      else $error("pointer byte order wrong");
   a_ptr_predec: assert property (ptr_upd_in && ptr_mode_in == CRF_PM_DEC && ptr_sel_in == CRF_PTR_Z
      && !dbg_wr_in |=> {state_reg.gpr[31], state_reg.gpr[30]} == $past(ptr_base) - 16'h0001)
      else $error("pre-decrement write back wrong");
   a_prog_ext_top: assert property (prog_addr_out[23:16] == state_reg.ext
      && prog_addr_out[15:0] == {state_reg.gpr[31], state_reg.gpr[30]})
      else $error("program address not extension plus third pointer");
   a_ext_bits_only: assert property ((state_reg.ext & ~`CRF_EXT_MASK) == 8'h00)
      else $error("unimplemented extension bits set");
   a_sig_opens_io: assert property (s_io_sig |=> io_unlock_out && !spm_unlock_out)
      else $error("io signature did not open io window");
   a_window_four: assert property (s_io_sig ##1 s_quiet_insn ##1 s_quiet_insn
      ##1 s_quiet_insn ##1 s_quiet_insn |=> !io_unlock_out)
      else $error("io window not closed after four instructions");
   a_irq_held: assert property ((io_unlock_out || spm_unlock_out) |-> !irq_take_out)
      else $error("interrupt taken inside window");
   a_io_cancel: assert property (io_unlock_out && sleep_in && !key_wr |=> !io_unlock_out)
      else $error("sleep did not close io window");
   a_spm_cancel: assert property (spm_unlock_out && nv_access_in && !key_wr |=> !spm_unlock_out)
      else $error("nv access did not close spm window");
   a_key_readback: assert property (io_rd_in && io_addr_in == `CRF_OFS_KEY
      |=> io_rdata_out == {6'h00, $past(spm_unlock_out), $past(io_unlock_out)})
      else $error("key read value wrong");
endmodule
`default_nettype wire

// [src/crf_defs.svh]
// offsets, field positions, reset values and counts of the cpu register block
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH
`define CRF_OFS_KEY       6'h04
`define CRF_OFS_EXT       6'h0B
`define CRF_OFS_SPL       6'h0D
`define CRF_OFS_SPH       6'h0E
`define CRF_OFS_FLAGS     6'h0F
`define CRF_SIG_IO        8'hD8
`define CRF_SIG_SPM       8'h9D
`define CRF_KEY_IO_BIT    0
`define CRF_KEY_SPM_BIT   1
`define CRF_EXT_MASK      8'h01
`define CRF_EXT_RESET     8'h00
`define CRF_SP_RESET      16'h7FFF
`define CRF_FLAGS_RESET   8'h00
`define CRF_KEY_RESET     8'h00
`define CRF_WIN_INSNS     3'h4
`define CRF_PTR_X_LO      5'h1A
`define CRF_PTR_Y_LO      5'h1C
`define CRF_PTR_Z_LO      5'h1E
`endif

// [src/crf_pkg.sv]
// types shared by the cpu register block and its users
package crf_pkg;
   // protection window state
   typedef enum logic [1:0] {CRF_WIN_IDLE, CRF_WIN_IO, CRF_WIN_SPM} crf_win_e;
   // pointer pair selection
   typedef enum logic [1:0] {CRF_PTR_X, CRF_PTR_Y, CRF_PTR_Z} crf_psel_e;
   // pointer addressing form
   typedef enum logic [1:0] {CRF_PM_DISP, CRF_PM_INC, CRF_PM_DEC} crf_pmode_e;
   // all state of the block
   typedef struct packed {
      logic [31:0][7:0] gpr;
      logic [7:0]       ext;
      logic [15:0]      sp;
      logic [7:0]       flags;
      crf_win_e         win;
      logic [2:0]       cnt;
      logic [7:0]       rdata;
      logic             brk;
   } crf_state_s;
endpackage

// [verification/crf_cpu_model.sv]
// behavioural model of the cpu pipeline that retires instructions on request
`timescale 1ns/1ps
`default_nettype none
module crf_cpu_model
(
   // clock
   input  wire logic mclk_in,
   // retire strobe towards the register block
   output var logic  insn_done_out
);
   // idle until the bench asks for instructions
   initial insn_done_out = 1'b0;
   // retire n instructions back to back, one per cycle; software places the
   // protected access inside the four-instruction span
   task automatic retire(input int n);
      insn_done_out = 1'b1;
      repeat (n) @(posedge mclk_in);
      #1 insn_done_out = 1'b0;
   endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the register file, pointer unit and change guard
`timescale 1ns/1ps
`default_nettype none
`include "crf_defs.svh"
module tb_top;
   import crf_pkg::*;
   // strobes and levels, idle at time zero except reset; interrupt request and the cof and irq break enables held high
   logic        mclk_in = 0, rst_in = 1, imm_op_in = 0, wr_en_in = 0, ptr_upd_in = 0;
   logic        io_wr_in = 0, io_rd_in = 0, flags_wr_in = 0, mem_wr_in = 0, nv_access_in = 0;
   logic        sleep_in = 0, irq_req_in = 1, halted_in = 0, dbg_wr_in = 0, bp_pc_en_in = 0;
   logic        cof_brk_en_in = 1, cof_in = 0, irq_brk_en_in = 1, irq_entry_in = 0, brk_insn_in = 0;
   logic [4:0]  rd_a_addr_in = 0, rd_b_addr_in = 0, wr_addr_in = 0, dbg_addr_in = 0;
   logic [7:0]  wr_data_in = 0, io_wdata_in = 0, flags_in = 0, dbg_data_in = 0;
   logic [5:0]  io_addr_in = 0, ptr_disp_in = 0;
   logic [16:0] bp_pc_in = 17'h1ABCD, program_counter_in = 17'h1ABCD;
   crf_psel_e   ptr_sel_in = CRF_PTR_X;
   crf_pmode_e  ptr_mode_in = CRF_PM_DISP;
   // design outputs
   logic [7:0]  rd_a_data_out, rd_b_data_out, io_rdata_out, result_flags_out;
   logic [15:0] ptr_addr_out, stack_pointer_out;
   logic [23:0] prog_addr_out;
   logic        io_unlock_out, spm_unlock_out, irq_take_out, break_out;
   wire         insn_done_in;
   int          fails = 0, checked = 0;
   // 40 MHz clock
   always #12.5 mclk_in = ~mclk_in;
   crf_core DUT (.*);
   crf_cpu_model cpu (.mclk_in(mclk_in), .insn_done_out(insn_done_in));
   // inputs move 1 ns after the edge so the design samples settled values
   task automatic tick(input int n = 1);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // every strobe task ends with an idle cycle so no signal is set twice in one step
   task automatic pulse(ref logic s);
      s = 1;
      tick();
      s = 0;
      tick();
   endtask
   task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
      io_addr_in = a;
      io_wdata_in = d;
      pulse(io_wr_in);
   endtask
   // read data stands one cycle only, so it is compared before the idle cycle
   task automatic io_rd(input logic [5:0] a, input logic [7:0] exp);
      io_addr_in = a;
      io_rd_in = 1;
      tick();
      io_rd_in = 0;
      chk(io_rdata_out, exp);
      tick();
   endtask
   task automatic gw(input logic [4:0] a, input logic [7:0] d);
      wr_addr_in = a;
      wr_data_in = d;
      pulse(wr_en_in);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard, far beyond the few hundred cycles the sequence needs
   initial
   begin
      #200000;
      fails++;
      print_verdict();
   end
   // main sequence
   initial
   begin
      tick(2);
      rst_in = 0;
      tick();
      io_rd(`CRF_OFS_SPH, 8'h7F);
      io_rd(`CRF_OFS_KEY, 8'h00);
      io_wr(6'h05, 8'h3C);
      io_rd(6'h05, 8'h00);
      io_wr(`CRF_OFS_EXT, 8'hFF);
      io_rd(`CRF_OFS_EXT, 8'h01);
      io_wr(`CRF_OFS_SPL, 8'h34);
      io_wr(`CRF_OFS_SPH, 8'h12);
      chk(stack_pointer_out, 16'h1234);
      flags_in = 8'hA5;
      pulse(flags_wr_in);
      chk(result_flags_out, 8'hA5);
      io_rd(`CRF_OFS_FLAGS, 8'hA5);
      // fill all 32 registers, then read them back on port b
      for (int i = 0; i < 32; i++) gw(5'(i), 8'(8'h40 + i));
      for (int i = 0; i < 32; i++)
      begin
         rd_b_addr_in = 5'(i);
         tick();
         chk(rd_b_data_out, 8'(8'h40 + i));
      end
      // immediate operand form reaches the upper half only
      imm_op_in = 1;
      rd_a_addr_in = 5'h03;
      tick();
      chk(rd_a_data_out, 8'h53);
      gw(5'h02, 8'hE1);
      imm_op_in = 0;
      rd_b_addr_in = 5'd18;
      tick();
      chk(rd_b_data_out, 8'hE1);
      // the lower twin of the mapped index keeps its old value
      rd_b_addr_in = 5'd2;
      tick();
      chk(rd_b_data_out, 8'h42);
      // load each pointer pair and check the displacement form at the top value
      ptr_disp_in = 6'h3F;
      for (int p = 0; p < 3; p++)
      begin
         gw(5'(26 + 2 * p), 8'(8'h10 + p));
         gw(5'(27 + 2 * p), 8'(8'h80 + p));
         ptr_sel_in = crf_psel_e'(p);
         tick();
         chk(ptr_addr_out, 16'(16'h804F + 16'h0101 * p));
      end
      ptr_mode_in = CRF_PM_INC;
      tick();
      chk(ptr_addr_out, 16'h8212);
      pulse(ptr_upd_in);
      rd_b_addr_in = 5'd30;
      tick();
      chk(rd_b_data_out, 8'h13);
      ptr_mode_in = CRF_PM_DEC;
      tick();
      chk(ptr_addr_out, 16'h8212);
      pulse(ptr_upd_in);
      chk(prog_addr_out, 24'h018212);
      // second pointer: low byte from the lower register; program address stays on the third
      ptr_mode_in = CRF_PM_INC;
      ptr_sel_in = CRF_PTR_Y;
      tick();
      chk(ptr_addr_out, 16'h8111);
      chk(prog_addr_out, 24'h018212);
      // guard: a wrong key opens nothing, the io key opens for four instructions
      io_wr(`CRF_OFS_KEY, 8'h55);
      chk({io_unlock_out, spm_unlock_out}, 2'b00);
      io_wr(`CRF_OFS_KEY, `CRF_SIG_IO);
      chk(io_unlock_out, 1'b1);
      chk(irq_take_out, 1'b0);
      io_rd(`CRF_OFS_KEY, 8'h01);
      cpu.retire(3);
      tick();
      chk(io_unlock_out, 1'b1);
      cpu.retire(1);
      chk(io_unlock_out, 1'b0);
      chk(irq_take_out, 1'b1);
      // retirement right behind the key write closes after the fourth instruction
      io_addr_in = `CRF_OFS_KEY;
      io_wdata_in = `CRF_SIG_IO;
      io_wr_in = 1;
      tick();
      io_wr_in = 0;
      cpu.retire(4);
      chk(io_unlock_out, 1'b0);
      // each cancelling event closes the io window early
      for (int k = 0; k < 4; k++)
      begin
         io_wr(`CRF_OFS_KEY, `CRF_SIG_IO);
         case (k)
            0: pulse(mem_wr_in);
            1: pulse(nv_access_in);
            2: pulse(sleep_in);
            default: io_wr(6'h05, 8'h00);
         endcase
         chk(io_unlock_out, 1'b0);
      end
      // self-programming window survives data writes, closes on nv access and sleep
      io_wr(`CRF_OFS_KEY, `CRF_SIG_SPM);
      pulse(mem_wr_in);
      io_wr(6'h05, 8'h00);
      chk({io_unlock_out, spm_unlock_out}, 2'b01);
      io_rd(`CRF_OFS_KEY, 8'h02);
      pulse(nv_access_in);
      chk(spm_unlock_out, 1'b0);
      io_wr(`CRF_OFS_KEY, `CRF_SIG_IO);
      io_wr(`CRF_OFS_KEY, `CRF_SIG_SPM);
      chk({io_unlock_out, spm_unlock_out}, 2'b01);
      pulse(sleep_in);
      chk(spm_unlock_out, 1'b0);
      // debugger writes land only while halted
      dbg_addr_in = 5'h07;
      dbg_data_in = 8'hC3;
      pulse(dbg_wr_in);
      rd_b_addr_in = 5'h07;
      tick();
      chk(rd_b_data_out, 8'h47);
      halted_in = 1;
      pulse(dbg_wr_in);
      chk(rd_b_data_out, 8'hC3);
      brk_insn_in = 1;
      tick();
      brk_insn_in = 0;
      chk(break_out, 1'b0);
      halted_in = 0;
      // every breakpoint source gives a one-cycle pulse
      for (int s = 0; s < 4; s++)
      begin
         case (s)
            0: bp_pc_en_in = 1;
            1: cof_in = 1;
            2: irq_entry_in = 1;
            default: brk_insn_in = 1;
         endcase
         tick();
         {bp_pc_en_in, cof_in, irq_entry_in, brk_insn_in} = 4'h0;
         chk(break_out, 1'b1);
         tick();
         chk(break_out, 1'b0);
      end
      // disabled sources and an address miss give no break
      cof_brk_en_in = 0;
      irq_brk_en_in = 0;
      program_counter_in = 17'h00000;
      {bp_pc_en_in, cof_in, irq_entry_in} = 3'b111;
      tick();
      {bp_pc_en_in, cof_in, irq_entry_in} = 3'b000;
      chk(break_out, 1'b0);
      // second reset in mid-run clears the file again
      rst_in = 1;
      tick();
      rst_in = 0;
      tick();
      chk(rd_b_data_out, 8'h00);
      io_rd(`CRF_OFS_EXT, 8'h00);
      print_verdict();
   end
endmodule
`default_nettype wire
